// >>> rtl/mtc_top.sv
// Behaviour
// - Single-attempt bit set: one try per frame, collided frame dropped.
// - Single-attempt clear: retry collided frame 16 times, then retry error.
// - Pad strip on: frames with length field below 46 lose pad and FCS.
// - Back-off field picks random bits: 00=10, 01=8, 10=4, 11=1.
// - Deferral check on: abort after deferring over 24,288 bit times.
// - Deferral counter runs while frame ready but carrier sense blocks.
// - Collision after transmission start clears the deferral counter.
// - Deferral check off: wait for carrier indefinitely, never abort.
// - Frames are sent only while the transmit enable bit is one.
// - Frames are accepted only while the receive enable bit is one.
// - Management address bits 15..11 select one of 32 PHYs.
// - Management address bits 10..6 select the PHY register.
// - Direction bit one writes the PHY register, zero reads it.
// - Busy flag is one while a management transaction runs.
// - Data register low 16 bits carry write data or read result.
`default_nettype none
module mtc_top
	#(
	parameter int DEFER_LIMIT = mtc_pkg::DEFER_CYCLES,
	parameter int LEN_W       = 12
	)
	(
	// Clock, reset, enable
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    clk_en,
	// Indirect register access
	input  wire mtc_pkg::mtc_reg_req_t   reg_req,
	output logic [31:0]                  reg_rdata,
	output logic                         reg_rvalid,
	// Transmit frame request and result
	input  wire logic                    tx_pending,
	input  wire logic [LEN_W-1:0]        tx_len_bytes,
	output mtc_pkg::mtc_tx_status_t      tx_status,
	// Receive frame decision
	input  wire mtc_pkg::mtc_rx_info_t   rx_info,
	output mtc_pkg::mtc_rx_verdict_t     rx_verdict,
	output logic [47:0]                  station_address,
	// MII transmit link
	input  wire logic                    tx_link_clk,
	input  wire logic                    mii_crs,
	input  wire logic                    mii_col,
	output logic                         mii_tx_en,
	// Management serial pins
	output logic                         mdc,
	input  wire logic                    mdio_i,
	output logic                         mdio_o,
	output logic                         mdio_oe
	);
	import mtc_pkg::*;

	//------------------------------------------------------------
	// Link-domain state
	//------------------------------------------------------------
	typedef struct packed {
		logic [4:0]     ctl_s1;
		logic [4:0]     ctl_s2;
		logic           req_s1;
		logic           req_s2;
		logic [2:0]     crs_s;
		logic [2:0]     col_s;
		logic           crs;
		logic           col;
		mtc_tx_state_t  state;
		logic           ack;
		mtc_tx_result_t result;
		logic [4:0]     retries;
		logic [15:0]    defer_cnt;
		logic [LEN_W:0] nib_cnt;
		logic [16:0]    bo_cnt;
		logic [9:0]     lfsr;
		logic           tx_en;
	} mtc_link_t;

	//------------------------------------------------------------
	// Core-domain state
	//------------------------------------------------------------
	typedef struct packed {
		logic [31:0]     control;
		logic [15:0]     addr_hi;
		logic [31:0]     addr_lo;
		logic [4:0]      phy_sel;
		logic [4:0]      reg_idx;
		logic            wr_sel;
		logic            busy;
		logic [15:0]     data;
		logic [31:0]     rdata;
		logic            rvalid;
		logic            ack_s1;
		logic            ack_s2;
		logic            ack_d;
		mtc_tx_status_t  status;
		logic [2:0]      mdio_s;
		logic            mdio_in;
		logic [4:0]      div;
		logic [5:0]      bit_idx;
		logic            mdc;
		logic            mdo;
		logic            oe;
		logic [15:0]     shift_in;
		mtc_rx_verdict_t verdict;
	} mtc_core_t;

	mtc_link_t lk;
	mtc_link_t next_lk;
	mtc_core_t cs;
	mtc_core_t next_cs;
	logic [4:0]  ctl_to_link;
	logic [63:0] mg_frame;
	logic        mg_start;

	// Back-off mask: field limit and the attempt count both cap it
	function automatic logic [9:0] bo_mask(input logic [1:0] lim,
		input logic [4:0] n);
		logic [9:0] m;
		case (lim)
			2'b00:   m = 10'h3FF;
			2'b01:   m = 10'h0FF;
			2'b10:   m = 10'h00F;
			default: m = 10'h001;
		endcase
		if (n < 5'd10)
			m = m & 10'(({1'b0, 10'h3FF} >> (5'd10 - n)));
		return m;
	endfunction

	// Quasi-static control bits handed to the link side
	assign ctl_to_link = {cs.control[CTL_SINGLE],
		cs.control[CTL_BOLMT_LO+1 -: 2], cs.control[CTL_DEFER],
		cs.control[CTL_TXON]};

	//------------------------------------------------------------
	// Transmit attempt engine (link clock)
	//------------------------------------------------------------
	always_comb
	begin
		next_lk = lk;
		next_lk.ctl_s1 = ctl_to_link;
		next_lk.ctl_s2 = lk.ctl_s1;
		next_lk.req_s1 = tx_pending;
		next_lk.req_s2 = lk.req_s1;
		next_lk.crs_s = {lk.crs_s[1:0], mii_crs};
		next_lk.col_s = {lk.col_s[1:0], mii_col};
		// Pin level counts only once stages two and three agree
		if (lk.crs_s[1] == lk.crs_s[2])
			next_lk.crs = lk.crs_s[2];
		if (lk.col_s[1] == lk.col_s[2])
			next_lk.col = lk.col_s[2];
		next_lk.lfsr = {lk.lfsr[8:0], lk.lfsr[9] ^ lk.lfsr[6]};
		case (lk.state)
			TX_IDLE:
			begin
				if (lk.req_s2 && !lk.ack && lk.ctl_s2[0])
				begin
					next_lk.state = TX_DEFER;
					next_lk.retries = 5'd0;
					next_lk.defer_cnt = 16'd0;
				end
			end
			TX_DEFER:
			begin
				if (lk.crs && lk.defer_cnt != 16'hFFFF)
					next_lk.defer_cnt = lk.defer_cnt + 16'd1;
				// deferral abort; waits forever when off
				if (lk.crs && lk.ctl_s2[1] &&
					32'(lk.defer_cnt) > DEFER_LIMIT)
				begin
					next_lk.result = RES_DEFER_ABORT;
					next_lk.state = TX_REPORT;
					next_lk.ack = 1'b1;
				end
				else if (!lk.crs && lk.ctl_s2[0])
				begin
					next_lk.state = TX_XMIT;
					next_lk.tx_en = 1'b1;
					next_lk.nib_cnt = {tx_len_bytes, 1'b0};
				end
			end
			TX_XMIT:
			begin
				if (lk.col)
				begin
					next_lk.tx_en = 1'b0;
					next_lk.defer_cnt = 16'd0;
					if (lk.ctl_s2[4])
					begin
						next_lk.result = RES_DROPPED;
						next_lk.state = TX_REPORT;
						next_lk.ack = 1'b1;
					end
					else if (32'(lk.retries) == RETRY_LIMIT)
					begin
						next_lk.result = RES_RETRY_ERR;
						next_lk.state = TX_REPORT;
						next_lk.ack = 1'b1;
					end
					else
					begin
						next_lk.retries = lk.retries + 5'd1;
						next_lk.bo_cnt = 17'(32'(lk.lfsr &
							bo_mask(lk.ctl_s2[3:2], lk.retries + 5'd1))
							* SLOT_CYCLES);
						next_lk.state = TX_BACKOFF;
					end
				end
				else if (lk.nib_cnt <= (LEN_W+1)'(1))
				begin
					next_lk.tx_en = 1'b0;
					next_lk.result = RES_SENT;
					next_lk.state = TX_REPORT;
					next_lk.ack = 1'b1;
				end
				else
					next_lk.nib_cnt = lk.nib_cnt - (LEN_W+1)'(1);
			end
			TX_BACKOFF:
			begin
				if (lk.bo_cnt == 17'd0)
					next_lk.state = TX_DEFER;
				else
					next_lk.bo_cnt = lk.bo_cnt - 17'd1;
			end
			TX_REPORT:
			begin
				// Result held stable until the request is withdrawn
				if (!lk.req_s2)
				begin
					next_lk.ack = 1'b0;
					next_lk.state = TX_IDLE;
				end
			end
			default: next_lk.state = TX_IDLE;
		endcase
	end

	// Link register bank
	always_ff @(posedge tx_link_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lk <= '0;
			lk.lfsr <= 10'h001;
		end
		else
			lk <= next_lk;
	end

	// Clause 22 frame image: preamble, start, op, PHY, reg, turn, data
	assign mg_frame = {32'hFFFF_FFFF, 2'b01,
		cs.wr_sel ? 2'b01 : 2'b10, cs.phy_sel, cs.reg_idx,
		cs.wr_sel ? 2'b10 : 2'b00, cs.wr_sel ? cs.data : 16'h0000};
	assign mg_start = reg_req.wr && reg_req.addr == OFS_MGMT_ADDR &&
		!cs.busy;

	//------------------------------------------------------------
	// Registers, management master, receive decision (core clock)
	//------------------------------------------------------------
	always_comb
	begin
		next_cs = cs;
		next_cs.rvalid = reg_req.rd;
		next_cs.mdio_s = {cs.mdio_s[1:0], mdio_i};
		if (cs.mdio_s[1] == cs.mdio_s[2])
			next_cs.mdio_in = cs.mdio_s[2];
		// Transmit result returns by four-phase handshake
		next_cs.ack_s1 = lk.ack;
		next_cs.ack_s2 = cs.ack_s1;
		next_cs.ack_d = cs.ack_s2;
		next_cs.status.done = cs.ack_s2 && !cs.ack_d;
		if (cs.ack_s2 && !cs.ack_d)
		begin
			next_cs.status.result = lk.result;
			next_cs.status.retries = lk.retries;
		end
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				OFS_CONTROL:    next_cs.rdata = cs.control;
				OFS_ADDR_UPPER: next_cs.rdata = {16'hFFFF, cs.addr_hi};
				OFS_ADDR_LOWER: next_cs.rdata = cs.addr_lo;
				OFS_MGMT_ADDR:  next_cs.rdata = {16'h0000, cs.phy_sel,
					cs.reg_idx, 4'h0, cs.wr_sel, cs.busy};
				OFS_MGMT_DATA:  next_cs.rdata = {16'h0000, cs.data};
				default:        next_cs.rdata = 32'h0000_0000;
			endcase
		end
		if (reg_req.wr)
		begin
			case (reg_req.addr)
				OFS_CONTROL:    next_cs.control = reg_req.wdata;
				OFS_ADDR_UPPER: next_cs.addr_hi = reg_req.wdata[15:0];
				OFS_ADDR_LOWER: next_cs.addr_lo = reg_req.wdata;
				OFS_MGMT_DATA:  next_cs.data = reg_req.wdata[15:0];
				default:        next_cs.rvalid = reg_req.rd;
			endcase
		end
		if (mg_start)
		begin
			next_cs.phy_sel = reg_req.wdata[MA_PHY_LSB+:5];
			next_cs.reg_idx = reg_req.wdata[MA_REG_LSB+:5];
			next_cs.wr_sel = reg_req.wdata[MA_WRITE];
			next_cs.busy = 1'b1;
			next_cs.bit_idx = 6'd0;
			next_cs.div = 5'd0;
			next_cs.mdc = 1'b0;
			next_cs.mdo = 1'b1;
			next_cs.oe = 1'b1;
		end
		else if (cs.busy)
		begin
			if (32'(cs.div) == MDC_HALF_CYCLES - 1)
			begin
				next_cs.div = 5'd0;
				next_cs.mdc = !cs.mdc;
				// read bits sampled on rising MDC
				if (!cs.mdc && !cs.wr_sel &&
					32'(cs.bit_idx) >= MDIO_DATA_BIT)
					next_cs.shift_in = {cs.shift_in[14:0], cs.mdio_in};
				if (cs.mdc && 32'(cs.bit_idx) == MDIO_FRAME_BITS - 1)
				begin
					next_cs.busy = 1'b0;
					next_cs.oe = 1'b0;
					next_cs.mdo = 1'b0;
					if (!cs.wr_sel)
						next_cs.data = cs.shift_in;
				end
				else if (cs.mdc)
				begin
					// next frame bit on falling MDC
					next_cs.bit_idx = cs.bit_idx + 6'd1;
					next_cs.mdo = mg_frame[6'd62 - cs.bit_idx];
					next_cs.oe = cs.wr_sel ||
						32'(cs.bit_idx) + 1 < MDIO_TA_BIT;
				end
			end
			else
				next_cs.div = cs.div + 5'd1;
		end
		// receive gate; pad and FCS stripping
		next_cs.verdict.valid = rx_info.valid;
		if (rx_info.valid)
		begin
			next_cs.verdict.accept = cs.control[CTL_RXON];
			if (cs.control[CTL_PADSTRIP] &&
				32'(rx_info.len_field) < MIN_DATA_LEN)
				next_cs.verdict.keep_bytes =
					16'(rx_info.len_field + 16'(HDR_BYTES));
			else
				next_cs.verdict.keep_bytes = rx_info.byte_count;
		end
	end

	// Core register bank, frozen while the enable is low
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cs <= '0;
			cs.control <= RST_CONTROL;
			cs.addr_hi <= RST_ADDR_UPPER;
			cs.addr_lo <= RST_ADDR_LOWER;
			{cs.phy_sel, cs.reg_idx} <= RST_MGMT_ADDR[15:6];
			cs.data <= RST_MGMT_DATA;
		end
		else if (clk_en)
			cs <= next_cs;
	end

	// Outputs
	assign reg_rdata = cs.rdata;
	assign reg_rvalid = cs.rvalid;
	assign tx_status = cs.status;
	assign rx_verdict = cs.verdict;
	assign station_address = {cs.addr_hi, cs.addr_lo};
	assign mii_tx_en = lk.tx_en;
	assign mdc = cs.mdc;
	assign mdio_o = cs.mdo;
	assign mdio_oe = cs.oe;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	sequence mg_start_s;
		clk_en && mg_start;
	endsequence
	mg_busy_a: assert property (@(posedge clk) disable iff (!resetn)
		mg_start_s |=> cs.busy [*8]) else $error("busy not held");
	mg_read_oe_a: assert property (@(posedge clk) disable iff (!resetn)
		cs.busy && !cs.wr_sel && cs.bit_idx > 6'd46 |-> !mdio_oe)
		else $error("drive during read");
	mg_pre_a: assert property (@(posedge clk) disable iff (!resetn)
		cs.busy && cs.bit_idx < 6'd32 |-> mdio_o && mdio_oe)
		else $error("bad preamble");
	rx_drop_a: assert property (@(posedge clk) disable iff (!resetn)
		clk_en && rx_info.valid && !cs.control[CTL_RXON]
		|=> rx_verdict.valid && !rx_verdict.accept)
		else $error("frame accepted while off");
	rx_strip_a: assert property (@(posedge clk) disable iff (!resetn)
		clk_en && rx_info.valid && cs.control[CTL_PADSTRIP] &&
		32'(rx_info.len_field) < MIN_DATA_LEN |=> rx_verdict.keep_bytes ==
		$past(rx_info.len_field) + 16'(HDR_BYTES)) else $error("pad kept");
	tx_gate_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_IDLE && !lk.ctl_s2[0]
		|=> lk.state == TX_IDLE) else $error("sent while disabled");
	tx_single_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_XMIT && lk.col &&
		lk.ctl_s2[4] |=> lk.state == TX_REPORT && lk.result ==
		RES_DROPPED && !mii_tx_en) else $error("no drop");
	tx_retry_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_XMIT && lk.col &&
		!lk.ctl_s2[4] && lk.retries == 5'd16 |=>
		lk.result == RES_RETRY_ERR) else $error("no retry error");
	tx_defclr_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_XMIT && lk.col
		|=> lk.defer_cnt == 16'd0) else $error("deferral kept");
	tx_defcnt_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_DEFER && lk.crs &&
		lk.defer_cnt < 16'd100 |=> lk.defer_cnt ==
		$past(lk.defer_cnt) + 16'd1) else $error("deferral stuck");
	tx_abort_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_DEFER && lk.crs &&
		lk.ctl_s2[1] && 32'(lk.defer_cnt) > DEFER_LIMIT |=>
		lk.result == RES_DEFER_ABORT) else $error("no abort");
	tx_wait_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_DEFER && lk.crs &&
		!lk.ctl_s2[1] |=> lk.state == TX_DEFER) else $error("gave up");
	tx_bolim_a: assert property (@(posedge tx_link_clk)
		disable iff (!resetn) lk.state == TX_BACKOFF &&
		lk.ctl_s2[3:2] == 2'b11 |-> lk.bo_cnt < 17'd256)
		else $error("back-off too long");
endmodule // mtc_top
`default_nettype wire

// >>> rtl/mtc_pkg.sv
`default_nettype none
package mtc_pkg;
	//------------------------------------------------------------
	// Register offsets (indirect address space)
	//------------------------------------------------------------
	localparam logic [15:0] OFS_CONTROL    = 16'h0000;
	localparam logic [15:0] OFS_ADDR_UPPER = 16'h0004;
	localparam logic [15:0] OFS_ADDR_LOWER = 16'h0008;
	localparam logic [15:0] OFS_MGMT_ADDR  = 16'h0014;
	localparam logic [15:0] OFS_MGMT_DATA  = 16'h0018;
	//------------------------------------------------------------
	// Field positions
	//------------------------------------------------------------
	localparam int CTL_SINGLE   = 10;
	localparam int CTL_PADSTRIP = 8;
	localparam int CTL_BOLMT_LO = 6;
	localparam int CTL_DEFER    = 5;
	localparam int CTL_TXON     = 3;
	localparam int CTL_RXON     = 2;
	localparam int MA_PHY_LSB   = 11;
	localparam int MA_REG_LSB   = 6;
	localparam int MA_WRITE     = 1;
	localparam int MA_BUSY      = 0;
	//------------------------------------------------------------
	// Reset values
	//------------------------------------------------------------
	localparam logic [31:0] RST_CONTROL    = 32'h0000_0000;
	localparam logic [15:0] RST_ADDR_UPPER = 16'hFFFF;
	localparam logic [31:0] RST_ADDR_LOWER = 32'hFFFF_FFFF;
	localparam logic [15:0] RST_MGMT_ADDR  = 16'h5AC0;
	localparam logic [15:0] RST_MGMT_DATA  = 16'h0000;
	//------------------------------------------------------------
	// Timing and protocol counts
	//------------------------------------------------------------
	localparam int DEFER_BIT_TIMES   = 24288;
	localparam int BITS_PER_LINK_CLK = 4;
	localparam int DEFER_CYCLES      = DEFER_BIT_TIMES / BITS_PER_LINK_CLK;
	localparam int SLOT_BIT_TIMES    = 512;
	localparam int SLOT_CYCLES       = SLOT_BIT_TIMES / BITS_PER_LINK_CLK;
	localparam int RETRY_LIMIT       = 16;
	localparam int MIN_DATA_LEN      = 46;
	localparam int HDR_BYTES         = 14;
	localparam int CLK_HZ            = 50_000_000;
	localparam int MDC_MAX_HZ        = 2_500_000;
	localparam int MDC_HALF_CYCLES   =
		(CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
	localparam int MDIO_FRAME_BITS   = 64;
	localparam int MDIO_TA_BIT       = 46;
	localparam int MDIO_DATA_BIT     = 48;
	//------------------------------------------------------------
	// Types
	//------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_DEFER = 3'b001, TX_XMIT = 3'b010,
		TX_BACKOFF = 3'b011, TX_REPORT = 3'b100
	} mtc_tx_state_t;
	typedef enum logic [1:0] {
		RES_SENT = 2'b00, RES_DROPPED = 2'b01,
		RES_RETRY_ERR = 2'b10, RES_DEFER_ABORT = 2'b11
	} mtc_tx_result_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} mtc_reg_req_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] len_field;
		logic [15:0] byte_count;
	} mtc_rx_info_t;
	typedef struct packed {
		logic        valid;
		logic        accept;
		logic [15:0] keep_bytes;
	} mtc_rx_verdict_t;
	typedef struct packed {
		logic           done;
		mtc_tx_result_t result;
		logic [4:0]     retries;
	} mtc_tx_status_t;
endpackage
`default_nettype wire

// >>> sim/mtc_phy_model.sv
`default_nettype none
module mtc_phy_model
	#(parameter logic [4:0] PHY_ADDR = 5'h03)
	(
	// Management pins
	input  wire logic mdc,
	input  wire logic mdio,
	output logic      phy_oe,
	output logic      phy_o,
	// MII pins and scenario controls
	input  wire logic tx_link_clk,
	input  wire logic mii_tx_en,
	input  wire logic crs_hold,
	input  wire logic col_on,
	output logic      mii_crs,
	output logic      mii_col
	);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] regs [32];
	logic [33:0] sh;
	logic [15:0] word;
	logic [11:0] hdr;
	logic        busy;
	int          cnt;
	// Per-index start pattern so that reads of different indices differ
	initial
	begin
		for (int i = 0; i < 32; i++)
			regs[i] = 16'hA500 | 16'(i);
		{sh, word, hdr, busy} = 63'h0;
		cnt = 0;
		{phy_oe, phy_o, mii_crs, mii_col} = 4'h4;
	end
	// --------------------------------------------------------------
	// Management frame, sampled on the rising management clock
	// --------------------------------------------------------------
	// serial frame decode
	always @(posedge mdc)
	begin
		sh = {sh[32:0], mdio};
		if (!busy)
		begin
			busy = (sh == {32'hFFFF_FFFF, 2'b01});
			cnt = 0;
		end
		else
		begin
			cnt++;
			if (cnt == 12)
				hdr = sh[11:0];
			if (hdr[11:10] == 2'b10 && hdr[9:5] == PHY_ADDR
				&& cnt >= 13 && cnt < 30)
			begin
				phy_oe = 1'b1;
				phy_o = (cnt == 13) ? 1'b0 : word[15];
				word = (cnt == 13) ? regs[hdr[4:0]] : {word[14:0], 1'b0};
			end
			// Line released at frame end; the pull-up then shows ones
			if (cnt == 30)
			begin
				{phy_oe, phy_o, busy} = 3'h2;
				if (hdr[11:10] == 2'b01 && hdr[9:5] == PHY_ADDR)
					regs[hdr[4:0]] = sh[15:0];
			end
		end
	end
	// Carrier also follows own transmission, as a half-duplex PHY does
	always @(posedge tx_link_clk)
	begin
		mii_crs <= crs_hold | mii_tx_en;
		mii_col <= col_on & mii_tx_en;
	end
endmodule // mtc_phy_model
`default_nettype wire

// >>> sim/mtc_top_tb.sv
`default_nettype none
module mtc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import mtc_pkg::*;
	localparam logic [4:0] PHY = 5'h03;
	logic            clk, resetn, clk_en, tx_link_clk, tx_pending;
	logic            reg_rvalid, mii_crs, mii_col, mii_tx_en, mdc;
	logic            mdio_o, mdio_oe, phy_oe, phy_o, crs_hold;
	wire logic       mdio_i, col_on;
	mtc_reg_req_t    reg_req;
	logic [31:0]     reg_rdata, rd;
	logic [11:0]     tx_len_bytes;
	mtc_tx_status_t  tx_status, st;
	mtc_rx_info_t    rx_info;
	mtc_rx_verdict_t rx_verdict;
	logic [47:0]     station_address;
	int              n_fail, checks, attempts, col_limit, en_cyc, gap;
	int              max_gap, n_done, waited, nd;
	// Open-drain style wire with pull-up
	assign mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
	assign col_on = (attempts <= col_limit);
	mtc_top #(.DEFER_LIMIT(40), .LEN_W(12)) u_mtc_top (
		.clk(clk), .resetn(resetn), .clk_en(clk_en), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.tx_pending(tx_pending), .tx_len_bytes(tx_len_bytes),
		.tx_status(tx_status), .rx_info(rx_info), .rx_verdict(rx_verdict),
		.station_address(station_address), .tx_link_clk(tx_link_clk),
		.mii_crs(mii_crs), .mii_col(mii_col), .mii_tx_en(mii_tx_en),
		.mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));
	mtc_phy_model #(.PHY_ADDR(PHY)) u_mtc_phy_model (
		.mdc(mdc), .mdio(mdio_i), .phy_oe(phy_oe), .phy_o(phy_o),
		.tx_link_clk(tx_link_clk), .mii_tx_en(mii_tx_en),
		.crs_hold(crs_hold), .col_on(col_on), .mii_crs(mii_crs),
		.mii_col(mii_col));
	// --------------------------------------------------------------
	// Clocks and link monitors
	// --------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Odd offset keeps the link clock out of phase with the core
	initial
	begin
		tx_link_clk = 1'b0;
		#7;
		forever #16 tx_link_clk = ~tx_link_clk;
	end
	always @(posedge tx_link_clk)
		if (mii_tx_en === 1'b1) en_cyc++; else gap++;
	// Idle gap before each retry shows the back-off span
	always @(posedge mii_tx_en)
	begin
		if (attempts > 0 && gap > max_gap) max_gap = gap;
		attempts++;
		gap = 0;
	end
	always @(posedge clk)
		if (tx_status.done === 1'b1) n_done++;
	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One idle cycle after each access keeps strobes single-driven
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		reg_req = {1'b1, 1'b0, a, d};
		@(posedge clk);
		#1 reg_req = '0;
		@(posedge clk);
		#1;
	endtask
	task automatic reg_rd(input logic [15:0] a);
		reg_req = {1'b0, 1'b1, a, 32'h0};
		@(posedge clk);
		#1 reg_req = '0;
		for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		check(48'(reg_rvalid), 48'h1);
		rd = reg_rdata;
		@(posedge clk);
		#1;
	endtask
	task automatic reg_chk(input logic [15:0] a, input logic [31:0] e);
		reg_rd(a);
		check(48'(rd), 48'(e));
	endtask
	// Start, try a refused restart while busy, poll, fetch data
	task automatic mg_run(input logic [4:0] p, input logic [4:0] r,
		input logic w);
		reg_wr(OFS_MGMT_ADDR, {16'h0, p, r, 4'h0, w, 1'b0});
		reg_rd(OFS_MGMT_ADDR);
		check(48'(rd[0]), 48'h1);
		reg_wr(OFS_MGMT_ADDR, {16'h0, ~p, ~r, 4'h0, ~w, 1'b0});
		for (int n = 0; n < 2000 && rd[0] !== 1'b0; n++)
			reg_rd(OFS_MGMT_ADDR);
		check(48'(rd), 48'({16'h0, p, r, 4'h0, w, 1'b0}));
		reg_rd(OFS_MGMT_DATA);
	endtask
	task automatic rx_chk(input logic [15:0] len, input logic acc,
		input logic [15:0] keep);
		rx_info = {1'b1, len, 16'h0040};
		@(posedge clk);
		#1 rx_info = '0;
		for (int i = 0; i < 4 && rx_verdict.valid !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		check(48'({rx_verdict.valid, rx_verdict.accept, rx_verdict.keep_bytes}),
			48'({1'b1, acc, keep}));
		@(posedge clk);
		#1;
	endtask
	task automatic tx_start(input logic [31:0] ctl, input int cols);
		reg_wr(OFS_CONTROL, ctl);
		repeat (8) @(posedge clk);
		#1 {attempts, en_cyc, max_gap, waited} = 128'h0;
		nd = n_done;
		col_limit = cols;
		tx_len_bytes = 12'h008;
		tx_pending = 1'b1;
	endtask
	// Bounded wait for the result, then the request is withdrawn
	task automatic tx_end();
		while (tx_status.done !== 1'b1 && waited < 20000)
		begin
			@(posedge clk);
			#1 waited++;
		end
		check(48'(tx_status.done), 48'h1);
		st = tx_status;
		tx_pending = 1'b0;
		repeat (40) @(posedge clk);
		#1;
	endtask
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	initial
	begin
		{resetn, tx_pending, crs_hold, clk_en} = 4'h1;
		{reg_req, rx_info, tx_len_bytes} = '0;
		{n_fail, checks, attempts, col_limit, gap, n_done} = 192'h0;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		reg_chk(OFS_CONTROL, 32'h0);
		reg_chk(OFS_ADDR_UPPER, 32'hFFFF_FFFF);
		reg_chk(OFS_ADDR_LOWER, 32'hFFFF_FFFF);
		reg_chk(OFS_MGMT_ADDR, 32'h0000_5AC0);
		reg_chk(OFS_MGMT_DATA, 32'h0);
		reg_chk(16'h000C, 32'h0);
		check(station_address, 48'hFFFF_FFFF_FFFF);
		reg_wr(OFS_ADDR_UPPER, 32'h1234_ABCD);
		reg_wr(OFS_ADDR_LOWER, 32'h0246_8ACE);
		reg_chk(OFS_ADDR_UPPER, 32'hFFFF_ABCD);
		reg_chk(OFS_ADDR_LOWER, 32'h0246_8ACE);
		check(station_address, 48'hABCD_0246_8ACE);
		// Enable low: a write in that span must not land
		clk_en = 1'b0;
		reg_wr(OFS_ADDR_LOWER, 32'h0000_0000);
		clk_en = 1'b1;
		reg_chk(OFS_ADDR_LOWER, 32'h0246_8ACE);
		// Management write, reads of two indices, absent PHY
		reg_wr(OFS_MGMT_DATA, 32'h0000_BEEF);
		mg_run(PHY, 5'h05, 1'b1);
		check(48'(u_mtc_phy_model.regs[5]), 48'hBEEF);
		check(48'(u_mtc_phy_model.regs[9]), 48'hA509);
		mg_run(PHY, 5'h09, 1'b0);
		check(48'(rd), 48'hA509);
		mg_run(PHY, 5'h05, 1'b0);
		check(48'(rd), 48'hBEEF);
		mg_run(PHY ^ 5'h01, 5'h05, 1'b0);
		check(48'(rd), 48'hFFFF);
		// Receive decisions around the 46-byte boundary
		reg_wr(OFS_CONTROL, 32'h0000_0104);
		rx_chk(16'h0014, 1'b1, 16'h0022);
		rx_chk(16'h002D, 1'b1, 16'h003B);
		rx_chk(16'h002E, 1'b1, 16'h0040);
		reg_wr(OFS_CONTROL, 32'h0000_0004);
		rx_chk(16'h0014, 1'b1, 16'h0040);
		reg_wr(OFS_CONTROL, 32'h0000_0000);
		rx_chk(16'h0014, 1'b0, 16'h0040);
		// Transmitter off with a frame queued, then switched on
		tx_start(32'h0000_0004, 0);
		repeat (300) @(posedge clk);
		#1 check(48'(attempts + n_done - nd), 48'h0);
		reg_wr(OFS_CONTROL, 32'h0000_000C);
		tx_end();
		check(48'({st.result, 8'(en_cyc)}), 48'({RES_SENT, 8'h10}));
		tx_start(32'h0000_040C, 100);
		tx_end();
		check(48'({st.result, 8'(attempts)}), 48'({RES_DROPPED, 8'h01}));
		tx_start(32'h0000_00CC, 100);
		tx_end();
		check(48'({st.result, 8'(attempts)}), 48'({RES_RETRY_ERR, 8'h11}));
		check(48'(max_gap <= 192), 48'h1);
		// Every back-off code, two collisions then success
		for (int c = 0; c < 4; c++)
		begin
			tx_start(32'h0000_000C | 32'(c << 6), 2);
			tx_end();
			check(48'({st.result, st.retries, 8'(attempts)}),
				48'({RES_SENT, 5'h02, 8'h03}));
			check(48'(max_gap <= (c == 3 ? 192 : 448)), 48'h1);
		end
		// Deferral abort under constant carrier, then unlimited wait
		crs_hold = 1'b1;
		tx_start(32'h0000_002C, 0);
		tx_end();
		check(48'({st.result, 8'(attempts)}), 48'({RES_DEFER_ABORT, 8'h00}));
		check(48'(waited >= 64 && waited < 120), 48'h1);
		tx_start(32'h0000_000C, 0);
		repeat (400) @(posedge clk);
		#1 check(48'(attempts + n_done - nd), 48'h0);
		crs_hold = 1'b0;
		tx_end();
		check(48'({st.result, 8'(en_cyc)}), 48'({RES_SENT, 8'h10}));
		close_out();
	end
	// Run needs well under a millisecond; this cuts a hang short
	initial
	begin
		#1_500_000;
		n_fail++;
		close_out();
	end
endmodule // mtc_top_tb
`default_nettype wire
